// ### core/acc_conv_ctrl.sv
`timescale 1ns/1ns
`include "acc_map.svh"
// What this block does
// RULE_01 - single-shot: one conversion, store, power down
// RULE_02 - continuous: restart immediately after each completion
// RULE_03 - continuous conversions run at programmed rate
// RULE_04 - result always holds last complete conversion
// RULE_05 - 3-bit field selects converter input pair
// RULE_06 - four single, one pair, three versus fourth
// RULE_07 - single-ended ties negative input to ground
// RULE_08 - single-ended selections never give negative codes
// RULE_09 - modulator clock is oscillator divided by four
// RULE_10 - filter turns bitstream into one code
// RULE_11 - 3-bit gain field sets full-scale range
// RULE_12 - code step is full scale over 2048
// RULE_13 - mode bit: one single-shot, zero continuous
// RULE_14 - start bit powers up, self-clears, ignored busy
// RULE_15 - reset loads defaults, powered down, bus alive
// RULE_16 - results are 12-bit signed twos complement
// RULE_17 - mux and gain changes apply next conversion
module acc_conv_ctrl import acc_pkg::*; (
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic        ce,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        mod_bit,
    output logic      [1:0]  analog_pos_sel,
    output logic      [1:0]  analog_neg_sel,
    output logic             neg_gnd_switch,
    output logic      [2:0]  gain_range_field,
    output logic             modulator_power,
    output logic             modulator_clk,
    output logic             conv_done
);
    localparam int CW = `ACC_CODE_BITS;

    acc_state_t  state;
    logic        mode;
    logic [2:0]  mux;
    logic [2:0]  gain;
    logic [2:0]  rate;
    logic [CW-1:0] result;
    logic [10:0] act_n;
    logic [21:0] act_k;
    logic        mod_bit_m;
    logic        mod_bit_s;

    acc_state_t  next_state;
    logic        next_mode;
    logic [2:0]  next_mux;
    logic [2:0]  next_gain;
    logic [2:0]  next_rate;
    logic [CW-1:0] next_result;
    logic [31:0] next_rdata;
    logic [10:0] next_act_n;
    logic [21:0] next_act_k;
    logic [1:0]  next_pos_sel;
    logic [1:0]  next_neg_sel;
    logic        next_gnd_sw;
    logic [2:0]  next_gain_out;
    logic        next_power;

    logic        wr_cfg;
    logic        start;
    logic        mod_tick;
    logic        fil_done;
    logic [CW-1:0] fil_code;

    acc_clk_div u_div (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .ce       (ce),
        .enable   (modulator_power),
        .mod_tick (mod_tick),
        .mod_clk  (modulator_clk)
    );

    acc_filter u_fil (
        .sys_clk     (sys_clk),
        .srst        (srst),
        .ce          (ce),
        .start       (start),
        .sample_tick (mod_tick),
        .mod_bit     (mod_bit_s),
        .n_samples   (act_n),
        .scale       (act_k),
        .clamp_pos   (neg_gnd_switch),
        .done        (fil_done),
        .code        (fil_code)
    );

    // configuration writes and conversion sequencing
    always_comb begin
        wr_cfg    = reg_wr && (reg_addr == `ACC_ADDR_CONFIG);
        next_mode = mode;
        next_mux  = mux;
        next_gain = gain;
        next_rate = rate;
        if (wr_cfg) begin
            next_mode = reg_wdata[`ACC_CFG_MODE]; // see RULE_13
            next_mux  = reg_wdata[`ACC_CFG_MUX_LSB +: 3];
            next_gain = reg_wdata[`ACC_CFG_GAIN_LSB +: 3];
            next_rate = reg_wdata[`ACC_CFG_RATE_LSB +: 3];
        end
        next_state = state;
        start      = 1'b0;
        case (state)
            ST_DOWN: begin
                if (!next_mode || (wr_cfg && reg_wdata[`ACC_CFG_START])) begin
                    start      = 1'b1; // see RULE_14
                    next_state = ST_CONV;
                end
            end
            ST_CONV: begin
                if (fil_done) begin
                    if (!next_mode) begin
                        start = 1'b1; // see RULE_02
                    end else begin
                        next_state = ST_DOWN; // see RULE_01
                    end
                end
            end
            default: next_state = ST_DOWN;
        endcase
        next_power    = (next_state == ST_CONV);
        next_result   = fil_done ? fil_code : result; // see RULE_04
        next_act_n    = act_n;
        next_act_k    = act_k;
        next_pos_sel  = analog_pos_sel;
        next_neg_sel  = analog_neg_sel;
        next_gnd_sw   = neg_gnd_switch;
        next_gain_out = gain_range_field;
        if (start) begin
            // settings are sampled only here, so a conversion never sees a change
            next_act_n    = acc_rate_samples(next_rate); // see RULE_03
            next_act_k    = acc_rate_scale(next_rate); // see RULE_12
            next_pos_sel  = acc_mux_pos(next_mux); // see RULE_05
            next_neg_sel  = acc_mux_neg(next_mux); // see RULE_06
            next_gnd_sw   = acc_mux_single(next_mux); // see RULE_07
            next_gain_out = next_gain; // see RULE_11
        end
    end

    // register read port, data valid only in the cycle after the strobe
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                `ACC_ADDR_CONFIG: begin
                    next_rdata[`ACC_CFG_MODE]          = mode;
                    next_rdata[`ACC_CFG_MUX_LSB +: 3]  = mux;
                    next_rdata[`ACC_CFG_GAIN_LSB +: 3] = gain;
                    next_rdata[`ACC_CFG_RATE_LSB +: 3] = rate;
                end
                `ACC_ADDR_RESULT: next_rdata = {{(32 - CW){result[CW-1]}}, result}; // see RULE_16
                `ACC_ADDR_STATUS: begin
                    next_rdata[`ACC_ST_BUSY]  = (state == ST_CONV);
                    next_rdata[`ACC_ST_POWER] = modulator_power;
                end
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state            <= ST_DOWN; // see RULE_15
            mode             <= `ACC_RST_MODE;
            mux              <= `ACC_RST_MUX;
            gain             <= `ACC_RST_GAIN;
            rate             <= `ACC_RST_RATE;
            result           <= '0;
            reg_rdata        <= 32'h0000_0000;
            act_n            <= 11'h000;
            act_k            <= 22'h00_0000;
            analog_pos_sel   <= 2'h0;
            analog_neg_sel   <= 2'h0;
            neg_gnd_switch   <= 1'b0;
            gain_range_field <= `ACC_RST_GAIN;
            modulator_power  <= 1'b0;
            conv_done        <= 1'b0;
            mod_bit_m        <= 1'b0;
            mod_bit_s        <= 1'b0;
        end else if (ce) begin
            state            <= next_state;
            mode             <= next_mode;
            mux              <= next_mux;
            gain             <= next_gain;
            rate             <= next_rate;
            result           <= next_result;
            reg_rdata        <= next_rdata;
            act_n            <= next_act_n;
            act_k            <= next_act_k;
            analog_pos_sel   <= next_pos_sel;
            analog_neg_sel   <= next_neg_sel;
            neg_gnd_switch   <= next_gnd_sw;
            gain_range_field <= next_gain_out;
            modulator_power  <= next_power;
            conv_done        <= fil_done;
            mod_bit_m        <= mod_bit;
            mod_bit_s        <= mod_bit_m;
        end
    end

    property p_ss_start;
        @(posedge sys_clk) disable iff (srst)
        ce && state == ST_DOWN && wr_cfg && reg_wdata[`ACC_CFG_START]
            |=> state == ST_CONV && modulator_power;
    endproperty
    a_ss_start: assert property (p_ss_start) else $error("start bit did not start"); // see RULE_14

    property p_ss_busy_ignored;
        @(posedge sys_clk) disable iff (srst)
        ce && state == ST_CONV && !fil_done |=> $stable(act_n) && $stable(analog_pos_sel);
    endproperty
    a_ss_busy_ignored: assert property (p_ss_busy_ignored) else $error("busy start not ignored"); // see RULE_17

    property p_single_down;
        @(posedge sys_clk) disable iff (srst)
        ce && state == ST_CONV && fil_done && mode && !wr_cfg
            |=> state == ST_DOWN ##1 !modulator_power;
    endproperty
    a_single_down: assert property (p_single_down) else $error("no power down after shot"); // see RULE_01

    property p_cont_restart;
        @(posedge sys_clk) disable iff (srst)
        ce && state == ST_CONV && fil_done && !mode && !wr_cfg |-> start;
    endproperty
    a_cont_restart: assert property (p_cont_restart) else $error("continuous did not restart"); // see RULE_02

    property p_result_update;
        @(posedge sys_clk) disable iff (srst)
        ce && fil_done |=> conv_done && result == $past(fil_code);
    endproperty
    a_result_update: assert property (p_result_update) else $error("result not stored"); // see RULE_04

    property p_result_hold;
        @(posedge sys_clk) disable iff (srst)
        ce && !fil_done |=> $stable(result);
    endproperty
    a_result_hold: assert property (p_result_hold) else $error("result changed mid conversion"); // see RULE_04

    property p_se_positive;
        @(posedge sys_clk) disable iff (srst)
        ce && fil_done && neg_gnd_switch |=> !result[CW-1];
    endproperty
    a_se_positive: assert property (p_se_positive) else $error("negative single-ended code"); // see RULE_08

    property p_gnd_switch;
        @(posedge sys_clk) disable iff (srst)
        ce && start |=> neg_gnd_switch == $past(next_mux[2])
            && (!neg_gnd_switch || analog_neg_sel == 2'h3);
    endproperty
    a_gnd_switch: assert property (p_gnd_switch) else $error("ground switch mismatch"); // see RULE_07

    property p_reset_down;
        @(posedge sys_clk) disable iff (srst)
        $past(srst) |-> state == ST_DOWN && mode && !modulator_power && !conv_done;
    endproperty
    a_reset_down: assert property (p_reset_down) else $error("reset state wrong"); // see RULE_15

    property p_rate_latch;
        @(posedge sys_clk) disable iff (srst)
        ce && start |=> act_n == acc_rate_samples($past(next_rate));
    endproperty
    a_rate_latch: assert property (p_rate_latch) else $error("rate not latched"); // see RULE_03
endmodule // acc_conv_ctrl

// ### core/acc_map.svh
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH

`define ACC_SYS_CLK_HZ    10000000
`define ACC_OSC_HZ        1000000
`define ACC_OSC_DIV       (`ACC_SYS_CLK_HZ / `ACC_OSC_HZ)
`define ACC_MOD_DIV       4
`define ACC_MOD_HZ        (`ACC_OSC_HZ / `ACC_MOD_DIV)
`define ACC_CODE_BITS     12
`define ACC_SCALE_SHIFT   16
`define ACC_SCALE_NUM     ((2 ** (`ACC_CODE_BITS - 1)) * (2 ** `ACC_SCALE_SHIFT))

`define ACC_ADDR_CONFIG   4'h0
`define ACC_ADDR_RESULT   4'h4
`define ACC_ADDR_STATUS   4'h8

`define ACC_CFG_MODE      0
`define ACC_CFG_START     1
`define ACC_CFG_MUX_LSB   2
`define ACC_CFG_GAIN_LSB  5
`define ACC_CFG_RATE_LSB  8
`define ACC_ST_BUSY       0
`define ACC_ST_POWER      1

`define ACC_RST_MODE      1'h1
`define ACC_RST_MUX       3'h0
`define ACC_RST_GAIN      3'h2
`define ACC_RST_RATE      3'h4

`define ACC_DR0           128
`define ACC_DR1           250
`define ACC_DR2           490
`define ACC_DR3           920
`define ACC_DR4           1600
`define ACC_DR5           2400
`define ACC_DR6           3300

`endif

// ### core/acc_pkg.sv
package acc_pkg;
`include "acc_map.svh"

    typedef enum logic {ST_DOWN, ST_CONV} acc_state_t;

    // 000 ch0-ch1, 001..011 ch0..ch2 against ch3, 100..111 ch0..ch3 against ground
    function automatic logic acc_mux_single(input logic [2:0] sel);
        return sel[2];
    endfunction

    function automatic logic [1:0] acc_mux_pos(input logic [2:0] sel);
        if (sel[2] || sel == 3'h0) begin
            return sel[1:0];
        end
        return sel[1:0] - 2'h1;
    endfunction

    function automatic logic [1:0] acc_mux_neg(input logic [2:0] sel);
        if (sel == 3'h0) begin
            return 2'h1;
        end
        return 2'h3;
    endfunction

    function automatic int acc_rate_sps(input logic [2:0] rate);
        case (rate)
            3'h0:    return `ACC_DR0;
            3'h1:    return `ACC_DR1;
            3'h2:    return `ACC_DR2;
            3'h3:    return `ACC_DR3;
            3'h4:    return `ACC_DR4;
            3'h5:    return `ACC_DR5;
            default: return `ACC_DR6;
        endcase
    endfunction

    function automatic logic [10:0] acc_rate_samples(input logic [2:0] rate);
        return 11'(`ACC_MOD_HZ / acc_rate_sps(rate));
    endfunction

    function automatic logic [21:0] acc_rate_scale(input logic [2:0] rate);
        return 22'(`ACC_SCALE_NUM / (`ACC_MOD_HZ / acc_rate_sps(rate)));
    endfunction
endpackage

// ### core/acc_clk_div.sv
`timescale 1ns/1ns
`include "acc_map.svh"
module acc_clk_div import acc_pkg::*; #(
    parameter int OSC_DIV = `ACC_OSC_DIV,
    parameter int MOD_DIV = `ACC_MOD_DIV
) (
    input  wire logic sys_clk,
    input  wire logic srst,
    input  wire logic ce,
    input  wire logic enable,
    output logic      mod_tick,
    output logic      mod_clk
);
    localparam int OW = $clog2(OSC_DIV);
    localparam int QW = $clog2(MOD_DIV);

    logic [OW-1:0] osc_cnt;
    logic [QW-1:0] quarter;
    logic [OW-1:0] next_osc_cnt;
    logic [QW-1:0] next_quarter;
    logic          next_mod_tick;
    logic          next_mod_clk;
    logic          osc_tick;

    // oscillator runs free; the modulator divider only while powered
    always_comb begin
        osc_tick      = (osc_cnt == OW'(OSC_DIV - 1));
        next_osc_cnt  = osc_tick ? '0 : osc_cnt + OW'(1);
        next_quarter  = quarter;
        next_mod_tick = 1'b0;
        next_mod_clk  = mod_clk;
        if (!enable) begin
            next_quarter = '0;
            next_mod_clk = 1'b0;
        end else if (osc_tick) begin
            next_quarter  = (quarter == QW'(MOD_DIV - 1)) ? '0 : quarter + QW'(1); // see RULE_09
            next_mod_tick = (quarter == QW'(MOD_DIV - 1));
            next_mod_clk  = (next_quarter >= QW'(MOD_DIV / 2));
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            osc_cnt  <= '0;
            quarter  <= '0;
            mod_tick <= 1'b0;
            mod_clk  <= 1'b0;
        end else if (ce) begin
            osc_cnt  <= next_osc_cnt;
            quarter  <= next_quarter;
            mod_tick <= next_mod_tick;
            mod_clk  <= next_mod_clk;
        end
    end
endmodule // acc_clk_div

// ### core/acc_filter.sv
`timescale 1ns/1ns
`include "acc_map.svh"
module acc_filter import acc_pkg::*; #(
    parameter int CODE_W = `ACC_CODE_BITS,
    parameter int CNT_W  = 11,
    parameter int K_W    = 22
) (
    input  wire logic              sys_clk,
    input  wire logic              srst,
    input  wire logic              ce,
    input  wire logic              start,
    input  wire logic              sample_tick,
    input  wire logic              mod_bit,
    input  wire logic [CNT_W-1:0]  n_samples,
    input  wire logic [K_W-1:0]    scale,
    input  wire logic              clamp_pos,
    output logic                   done,
    output logic [CODE_W-1:0]      code
);
    localparam int PW = CNT_W + K_W + 2;
    localparam logic signed [CNT_W:0] ONE  = (CNT_W + 1)'(1);
    localparam logic signed [PW-1:0]  MAXC = PW'((2 ** (CODE_W - 1)) - 1);
    localparam logic signed [PW-1:0]  MINC = PW'(-(2 ** (CODE_W - 1)));

    logic                    run;
    logic [CNT_W-1:0]        cnt;
    logic signed [CNT_W:0]   acc;
    logic                    fin;
    logic                    next_run;
    logic [CNT_W-1:0]        next_cnt;
    logic signed [CNT_W:0]   next_acc;
    logic                    next_fin;
    logic                    next_done;
    logic [CODE_W-1:0]       next_code;
    logic signed [PW-1:0]    prod;

    always_comb begin
        next_run  = run;
        next_cnt  = cnt;
        next_acc  = acc;
        next_fin  = 1'b0;
        next_done = 1'b0;
        next_code = code;
        prod      = (PW'(acc) * $signed({1'b0, scale})) >>> `ACC_SCALE_SHIFT;
        if (start) begin
            next_run = 1'b1;
            next_cnt = '0;
            next_acc = '0;
        end else if (run && sample_tick) begin
            next_acc = mod_bit ? acc + ONE : acc - ONE; // see RULE_10
            next_cnt = cnt + CNT_W'(1);
            if (cnt == n_samples - CNT_W'(1)) begin
                next_run = 1'b0;
                next_fin = 1'b1;
            end
        end
        if (fin) begin
            next_done = 1'b1;
            if (prod > MAXC) begin
                next_code = MAXC[CODE_W-1:0]; // see RULE_16
            end else if (prod < MINC) begin
                next_code = MINC[CODE_W-1:0];
            end else begin
                next_code = prod[CODE_W-1:0];
            end
            if (clamp_pos && prod < 0) begin
                next_code = '0; // see RULE_08
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            run  <= 1'b0;
            cnt  <= '0;
            acc  <= '0;
            fin  <= 1'b0;
            done <= 1'b0;
            code <= '0;
        end else if (ce) begin
            run  <= next_run;
            cnt  <= next_cnt;
            acc  <= next_acc;
            fin  <= next_fin;
            done <= next_done;
            code <= next_code;
        end
    end

    property p_count_bound;
        @(posedge sys_clk) disable iff (srst)
        run |-> cnt < n_samples;
    endproperty
    a_count_bound: assert property (p_count_bound) else $error("sample count overran"); // see RULE_10
endmodule // acc_filter

// ### testbench/acc_analog_model.sv
`timescale 1ns/1ns
// analog front end: turns the selected input difference into a modulator bitstream
module acc_analog_model (
    input  wire logic            sys_clk,
    input  wire logic            modulator_power,
    input  wire logic [1:0]      analog_pos_sel,
    input  wire logic [1:0]      analog_neg_sel,
    input  wire logic            neg_gnd_switch,
    input  wire logic [3:0][2:0] ch_val,
    output logic                 mod_bit
);
    int   diff;
    logic toggle = 1'b0;

    always_comb begin
        diff = int'($signed(ch_val[analog_pos_sel]));
        if (!neg_gnd_switch) begin
            diff = diff - int'($signed(ch_val[analog_neg_sel]));
        end
    end

    always @(posedge sys_clk) begin
        toggle <= ~toggle;
    end

    // an unpowered front end gives no steady level, so the line keeps changing
    always_comb begin
        if (modulator_power && diff > 0) begin
            mod_bit = 1'b1;
        end else if (modulator_power && diff < 0) begin
            mod_bit = 1'b0;
        end else begin
            mod_bit = toggle;
        end
    end
endmodule // acc_analog_model

// ### testbench/test_acc_conv_ctrl.sv
`timescale 1ns/1ns
module test_acc_conv_ctrl;
    localparam int LIMIT = 80000;
    logic            sys_clk = 1'b0;
    logic            srst = 1'b1;
    logic [3:0]      reg_addr = 4'h0;
    logic [31:0]     reg_wdata = 32'h0000_0000;
    logic            reg_wr = 1'b0;
    logic            reg_rd = 1'b0;
    logic [31:0]     reg_rdata;
    logic            mod_bit;
    logic [1:0]      analog_pos_sel;
    logic [1:0]      analog_neg_sel;
    logic            neg_gnd_switch;
    logic [2:0]      gain_range_field;
    logic            modulator_power;
    logic            modulator_clk;
    logic            conv_done;
    logic [3:0][2:0] ch_val;
    logic            mclk_q = 1'b0;
    logic [31:0]     rd;
    int              err_count = 0;
    int              check_count = 0;
    int              cycles = 0;
    int              mcnt = 0;
    int              mper = 0;
    int              dlast = 0;
    int              dgap = 0;
    int              n;
    int              chv [4] = '{2, -1, -2, 1};
    logic [1:0]      t_pos [8] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h0, 2'h1, 2'h2, 2'h3};
    logic [1:0]      t_neg [4] = '{2'h1, 2'h3, 2'h3, 2'h3};

    acc_conv_ctrl acc_conv_ctrl_inst (
        .sys_clk(sys_clk), .srst(srst), .ce(1'b1), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .mod_bit(mod_bit), .analog_pos_sel(analog_pos_sel), .analog_neg_sel(analog_neg_sel),
        .neg_gnd_switch(neg_gnd_switch), .gain_range_field(gain_range_field),
        .modulator_power(modulator_power), .modulator_clk(modulator_clk),
        .conv_done(conv_done)
    );

    acc_analog_model acc_analog_model_inst (
        .sys_clk(sys_clk), .modulator_power(modulator_power),
        .analog_pos_sel(analog_pos_sel), .analog_neg_sel(analog_neg_sel),
        .neg_gnd_switch(neg_gnd_switch), .ch_val(ch_val), .mod_bit(mod_bit)
    );

    always #50 sys_clk = ~sys_clk;

    task automatic test_done();
        $display("checks %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // cycle counter, modulator clock period and spacing of completions
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        mclk_q <= modulator_clk;
        mcnt   <= (modulator_clk && !mclk_q) ? 1 : mcnt + 1;
        if (modulator_clk && !mclk_q) begin
            mper <= mcnt;
        end
        if (conv_done === 1'b1) begin
            dgap  <= cycles - dlast;
            dlast <= cycles;
        end
        if (cycles == LIMIT) begin
            err_count++;
            test_done();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic wait_done(output int c);
        @(posedge sys_clk);
        #1 c = 1;
        while (conv_done !== 1'b1 && c < 5000) begin
            @(posedge sys_clk);
            #1 c++;
        end
        check("completion", 32'(conv_done), 32'h0000_0001);
    endtask

    function automatic logic [31:0] cfg(input logic m, input logic s,
                                        input logic [2:0] mx, input logic [2:0] g,
                                        input logic [2:0] r);
        return {21'h0, r, g, mx, s, m};
    endfunction

    // full-scale or clamped-to-zero code expected for the model's fixed input levels
    function automatic logic [31:0] exp_code(input int sel);
        int d;
        d = chv[t_pos[sel]] - ((sel >= 4) ? 0 : chv[t_neg[sel]]);
        if (d > 0) begin
            return 32'h0000_07FF;
        end
        return (sel >= 4) ? 32'h0000_0000 : 32'hFFFF_F800;
    endfunction

    initial begin
        for (int i = 0; i < 4; i++) begin
            ch_val[i] = 3'(chv[i]);
        end
        repeat (8) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        #1;
        check("power", 32'(modulator_power), 32'h0000_0000);
        check("modulator clock", 32'(modulator_clk), 32'h0000_0000);
        check("gain out", 32'(gain_range_field), 32'h0000_0002);
        reg_read(4'h0, rd);
        check("config", rd, 32'h0000_0441);
        reg_read(4'h8, rd);
        check("status", rd, 32'h0000_0000);
        reg_read(4'hC, rd);
        check("unmapped", rd, 32'h0000_0000);
        for (int i = 0; i < 8; i++) begin
            reg_write(4'h0, cfg(1'b1, 1'b1, 3'(i), 3'(i), 3'h6));
            @(posedge sys_clk);
            #1;
            check("power up", 32'(modulator_power), 32'h0000_0001);
            check("pos sel", 32'(analog_pos_sel), 32'(t_pos[i]));
            if (i < 4) begin
                check("neg sel", 32'(analog_neg_sel), 32'(t_neg[i]));
            end
            check("gnd switch", 32'(neg_gnd_switch), 32'(i / 4));
            check("gain", 32'(gain_range_field), 32'(i));
            reg_read(4'h0, rd);
            check("start bit", 32'(rd[1]), 32'h0000_0000);
            if (i == 3) begin
                reg_write(4'h0, cfg(1'b1, 1'b1, 3'h7, 3'h0, 3'h6));
                reg_read(4'h4, rd);
                check("result mid", rd, exp_code(2));
                check("pos held", 32'(analog_pos_sel), 32'(t_pos[3]));
                check("gain held", 32'(gain_range_field), 32'h0000_0003);
            end
            wait_done(n);
            check("conv time", 32'(n >= 2950 && n <= 3030), 32'h0000_0001);
            check("mod period", 32'(mper), 32'h0000_0028);
            reg_read(4'h4, rd);
            check("result", rd, exp_code(i));
            reg_read(4'h8, rd);
            check("idle status", rd, 32'h0000_0000);
        end
        reg_write(4'h0, cfg(1'b0, 1'b0, 3'h3, 3'h1, 3'h6));
        wait_done(n);
        reg_write(4'h0, cfg(1'b0, 1'b0, 3'h4, 3'h1, 3'h5));
        wait_done(n);
        @(posedge sys_clk);
        #1;
        check("gap rate 6", 32'(dgap >= 3000 && dgap <= 3010), 32'h0000_0001);
        check("still powered", 32'(modulator_power), 32'h0000_0001);
        check("gnd after restart", 32'(neg_gnd_switch), 32'h0000_0001);
        reg_read(4'h4, rd);
        check("result cont", rd, exp_code(3));
        wait_done(n);
        reg_write(4'h0, cfg(1'b1, 1'b0, 3'h4, 3'h1, 3'h5));
        check("gap rate 5", 32'(dgap >= 4160 && dgap <= 4170), 32'h0000_0001);
        reg_read(4'h4, rd);
        check("result single", rd, exp_code(4));
        wait_done(n);
        @(posedge sys_clk);
        #1;
        check("power off", 32'(modulator_power), 32'h0000_0000);
        test_done();
    end
endmodule // test_acc_conv_ctrl
